// [logic/sbsp_pkg.sv]
// package for the synchronous burst sram port: sizes, burst counter, lanes
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package sbsp_pkg;
  localparam int ADDR_W = 15;
  localparam int WORDS = 32768;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = 32;
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic [1:0] BURST_CNT_STEP = 2'h1;
  localparam logic [3:0] LANES_IDLE = 4'hF;
endpackage
`default_nettype wire

// [logic/sbsp_core.sv]
// storage array of the synchronous burst sram with per-lane writes
// assumes write strobes already registered by the port logic
`timescale 1ns/100ps
`default_nettype none
module sbsp_core #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W,
  parameter int WORDS = sbsp_pkg::WORDS,
  parameter int LANES = sbsp_pkg::LANES,
  parameter int LANE_W = sbsp_pkg::LANE_W
) (
  // clock
  input wire logic i_clk,
  // write side
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [LANES-1:0] i_lane_we,
  input wire logic [LANES*(LANE_W+1)-1:0] i_wdata,
  // read side
  output logic [LANES*(LANE_W+1)-1:0] o_rdata
);
  localparam int LW = LANE_W + 1;

  // one lane per generate entry; unwritten lanes keep their contents
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LW-1:0] mem [WORDS];
    always_ff @(posedge i_clk) begin
      if (i_lane_we[g]) begin
        mem[i_addr] <= i_wdata[g*LW +: LW];
      end
    end
    // combinational read of the registered address
    assign o_rdata[g*LW +: LW] = mem[i_addr];
  end
endmodule
`default_nettype wire

// [logic/sbsp_port.sv]
// synchronous front end of a 32k x 36 burst sram
// assumes all sync inputs meet setup/hold at i_clk; data pins split in
// input, output and enable; reset only initialises control state
//
// Operation
// - array 32k x 36, 2-bit burst counter
// - all sync inputs captured on rising edge
// - 15-bit word address registered on edge
// - output enable low drives data, asynchronously
// - writes one to four lanes, others kept
// - each write enable covers one byte plus parity
// - any lane enable low means write, except on a cpu strobe
// - data pins released while any enable low
// - primary enable sampled only at address load
// - other enables ignored during burst continuation
// - advance low steps burst counter
// - advance high holds address, wait state
// - cpu strobe aborts burst, loads address
// - cpu strobe access is always read
// - cpu strobe ignored when primary enable high
// - cpu strobe with other enables off deselects
// - ctl strobe loads address, read or write
// - ctl strobe with any enable off deselects
// - writes self-timed from registered controls
// - interleaved burst order, wraps after four
// - parity off disables parity lines
`timescale 1ns/100ps
`default_nettype none
module sbsp_port #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W,
  parameter int WORDS = sbsp_pkg::WORDS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // address and strobes
  input wire logic [ADDR_W-1:0] i_word_addr_in,
  input wire logic i_addr_strobe_cpu_n,
  input wire logic i_addr_strobe_ctl_n,
  input wire logic i_burst_step_n,
  // chip selects
  input wire logic i_chip_sel_n,
  input wire logic i_chip_sel_secondary_n,
  input wire logic i_chip_sel_positive,
  // byte lane write enables
  input wire logic i_lane0_write_n,
  input wire logic i_lane1_write_n,
  input wire logic i_lane2_write_n,
  input wire logic i_lane3_write_n,
  // asynchronous output enable and parity control
  input wire logic i_out_en_n,
  input wire logic i_parity_off,
  // data and parity pins
  input wire logic [sbsp_pkg::DATA_W-1:0] i_data_lines,
  input wire logic [sbsp_pkg::LANES-1:0] i_parity_lines,
  output logic [sbsp_pkg::DATA_W-1:0] o_data_lines,
  output logic [sbsp_pkg::LANES-1:0] o_parity_lines,
  output logic o_data_oe,
  output logic o_parity_oe
);
  localparam int LANES = sbsp_pkg::LANES;
  localparam int LW = sbsp_pkg::LANE_W + 1;

  // the array is indexed by the full word address, so depth is fixed
  if (WORDS != (1 << ADDR_W)) begin : g_bad_depth
    $error("depth must match address width");
  end

  typedef enum logic [1:0] {
    SBSP_IDLE,
    SBSP_READ,
    SBSP_WRITE
  } sbsp_mode_t;

  typedef struct packed {
    sbsp_mode_t mode;
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    logic [LANES-1:0] we;
    logic [LANES*LW-1:0] wdata;
    logic [LANES*LW-1:0] dout;
    logic drive;
  } sbsp_state_t;

  sbsp_state_t st_reg;
  sbsp_state_t st_next;
  logic [LANES-1:0] lane_wr;
  logic [ADDR_W-1:0] cur_addr;
  logic [LANES*LW-1:0] din;
  logic [LANES*LW-1:0] rdata;
  logic cpu_load;
  logic ctl_load;
  logic sel_ok;

  // lane enables active high; lane g owns byte g and parity bit g
  assign lane_wr = ~{i_lane3_write_n, i_lane2_write_n,
                     i_lane1_write_n, i_lane0_write_n};

  // pack pins into 9-bit lanes: data byte then parity bit on top
  for (genvar g = 0; g < LANES; g++) begin : g_pack
    assign din[g*LW +: LW] = {i_parity_lines[g],
                              i_data_lines[g*8 +: 8]};
    assign o_data_lines[g*8 +: 8] = st_reg.dout[g*LW +: 8];
    assign o_parity_lines[g] = st_reg.dout[g*LW+8];
  end

  // interleaved burst: low bits xor count, wrap after fourth
  assign cur_addr = {st_reg.base[ADDR_W-1:2],
                     st_reg.base[1:0] ^ st_reg.cnt};

  // strobe qualification; primary enable only looked at on loads
  assign cpu_load = !i_addr_strobe_cpu_n && !i_chip_sel_n;
  assign ctl_load = !i_addr_strobe_ctl_n && !cpu_load;
  assign sel_ok = !i_chip_sel_secondary_n && i_chip_sel_positive;

  // the array sees the registered address and write strobes only,
  // so writes need no external pulse
  sbsp_core #(
    .ADDR_W(ADDR_W),
    .WORDS(WORDS),
    .LANES(LANES),
    .LANE_W(sbsp_pkg::LANE_W)
  ) i_sbsp_core (
    .i_clk(i_clk),
    .i_addr(cur_addr),
    .i_lane_we(st_reg.mode == SBSP_WRITE ? st_reg.we : '0),
    .i_wdata(st_reg.wdata),
    .o_rdata(rdata)
  );

  // next state of the access sequencer
  always_comb begin
    st_next = st_reg;
    st_next.we = lane_wr;
    st_next.wdata = din;
    if (cpu_load) begin
      // abort burst, fresh address, always a read
      st_next.base = i_word_addr_in;
      st_next.cnt = sbsp_pkg::BURST_CNT_RST;
      st_next.mode = sel_ok ? SBSP_READ : SBSP_IDLE;
      st_next.we = '0;
    end else if (ctl_load) begin
      st_next.base = i_word_addr_in;
      st_next.cnt = sbsp_pkg::BURST_CNT_RST;
      if (sel_ok && !i_chip_sel_n) begin
        st_next.mode = |lane_wr ? SBSP_WRITE : SBSP_READ;
      end else begin
        st_next.mode = SBSP_IDLE;
      end
    end else if (st_reg.mode != SBSP_IDLE) begin
      // continuation ignores all chip selects
      if (!i_burst_step_n) begin
        st_next.cnt = st_reg.cnt + sbsp_pkg::BURST_CNT_STEP;
      end // high advance repeats the same address
      st_next.mode = |lane_wr ? SBSP_WRITE : SBSP_READ;
    end
    // read data for the cycle just registered; parity gated off
    st_next.dout = rdata;
    if (i_parity_off) begin
      for (int k = 0; k < LANES; k++) begin
        st_next.dout[k*LW+8] = 1'b0;
      end
    end
    // drive belongs to the access whose data is latched now, so a
    // later deselect does not hide the last word of a read
    st_next.drive = (st_reg.mode == SBSP_READ) && !(|lane_wr);
  end

  // one register stage for all control state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '{mode: SBSP_IDLE, base: '0,
                  cnt: sbsp_pkg::BURST_CNT_RST, we: '0,
                  wdata: '0, dout: '0, drive: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // output enable is a pin-level gate, so it acts without the clock;
  // the flop-sourced drive bit is ANDed in at the pad; a low lane
  // write enable releases the pins at once, otherwise the last read
  // word would fight the master's write data in that same cycle
  assign o_data_oe = st_reg.drive && !i_out_en_n && !(|lane_wr);
  assign o_parity_oe = st_reg.drive && !i_out_en_n && !(|lane_wr)
                       && !i_parity_off;

  // checks
  property p_cpu_read;
    @(posedge i_clk) disable iff (!i_rst_b)
      (cpu_load && sel_ok) |=> (st_reg.mode == SBSP_READ);
  endproperty
  a_cpu_read: assert property (p_cpu_read)
    else $error("cpu strobe did not start a read");

  property p_cpu_desel;
    @(posedge i_clk) disable iff (!i_rst_b)
      (cpu_load && !sel_ok) |=> (st_reg.mode == SBSP_IDLE);
  endproperty
  a_cpu_desel: assert property (p_cpu_desel)
    else $error("cpu strobe with enables off did not deselect");

  property p_ctl_desel;
    @(posedge i_clk) disable iff (!i_rst_b)
      (ctl_load && !(sel_ok && !i_chip_sel_n))
      |=> (st_reg.mode == SBSP_IDLE);
  endproperty
  a_ctl_desel: assert property (p_ctl_desel)
    else $error("ctl strobe with enable off did not deselect");

  property p_ctl_write;
    @(posedge i_clk) disable iff (!i_rst_b)
      (ctl_load && sel_ok && !i_chip_sel_n && |lane_wr)
      |=> (st_reg.mode == SBSP_WRITE && st_reg.we == $past(lane_wr));
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("ctl write not started");

  property p_load_addr;
    @(posedge i_clk) disable iff (!i_rst_b)
      (cpu_load || ctl_load)
      |=> (cur_addr == $past(i_word_addr_in));
  endproperty
  a_load_addr: assert property (p_load_addr)
    else $error("fresh address not loaded");

  sequence s_burst_step;
    !cpu_load && !ctl_load && st_reg.mode != SBSP_IDLE
      && !i_burst_step_n;
  endsequence
  property p_step;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_burst_step |=> (st_reg.cnt == $past(st_reg.cnt) + 2'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("burst counter did not step");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      (!cpu_load && !ctl_load && i_burst_step_n)
      |=> $stable(st_reg.cnt) && $stable(st_reg.base);
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst address moved in wait state");

  property p_hiz_write;
    @(posedge i_clk) disable iff (!i_rst_b)
      (|lane_wr) |=> !o_data_oe;
  endproperty
  a_hiz_write: assert property (p_hiz_write)
    else $error("data driven during write");

  property p_parity_off;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_parity_off |-> !o_parity_oe ##1 (o_parity_lines == '0);
  endproperty
  a_parity_off: assert property (p_parity_off)
    else $error("parity driven while disabled");

  property p_oe;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_out_en_n |-> !o_data_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data driven with output enable high");

  property p_hiz_now;
    @(posedge i_clk) disable iff (!i_rst_b)
      (|lane_wr) |-> !o_data_oe && !o_parity_oe;
  endproperty
  a_hiz_now: assert property (p_hiz_now)
    else $error("data driven while a lane write enable is low");

  property p_ctl_read;
    @(posedge i_clk) disable iff (!i_rst_b)
      (ctl_load && sel_ok && !i_chip_sel_n && !(|lane_wr))
      |=> (st_reg.mode == SBSP_READ);
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("ctl read not started");

  sequence s_cont_write;
    !cpu_load && !ctl_load && st_reg.mode != SBSP_IDLE && (|lane_wr);
  endsequence
  property p_cont_write;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_cont_write
      |=> (st_reg.mode == SBSP_WRITE && st_reg.we == $past(lane_wr));
  endproperty
  a_cont_write: assert property (p_cont_write)
    else $error("burst write not continued");

  property p_idle_stays;
    @(posedge i_clk) disable iff (!i_rst_b)
      (st_reg.mode == SBSP_IDLE && !cpu_load && !ctl_load)
      |=> (st_reg.mode == SBSP_IDLE);
  endproperty
  a_idle_stays: assert property (p_idle_stays)
    else $error("deselected port woke without a strobe");

  property p_no_drive;
    @(posedge i_clk) disable iff (!i_rst_b)
      (st_reg.mode != SBSP_READ) |=> !o_data_oe;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("data driven for a non-read access");
endmodule
`default_nettype wire

// [test/sbsp_bus_model.sv]
// processor-side model of the sram data and parity pins
// assumes the bench says when the master drives write data
`timescale 1ns/100ps
`default_nettype none
module sbsp_bus_model (
  // clock
  input wire logic i_clk,
  // master side
  input wire logic i_drv,
  input wire logic [35:0] i_wr,
  // device side
  input wire logic i_doe,
  input wire logic i_poe,
  input wire logic [35:0] i_rd,
  // resolved pins
  output logic [35:0] o_pin
);
  logic [35:0] last_reg;
  // undriven pins flip each cycle so a stale value never matches
  always_comb begin
    o_pin = ~last_reg;
    if (i_drv) o_pin = i_wr;
    if (i_doe) o_pin[31:0] = i_rd[31:0];
    if (i_poe) o_pin[35:32] = i_rd[35:32];
  end
  // remember the level for the next undriven cycle
  always_ff @(posedge i_clk) last_reg <= o_pin;
endmodule
`default_nettype wire

// [test/sync_burst_sram_port_test.sv]
// self-checking bench for the burst sram port
// assumes sbsp_pkg, sbsp_core, sbsp_port and sbsp_bus_model compiled
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_port_test;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cpu_n = 1'b1, ctl_n = 1'b1, step_n = 1'b1, drv = 1'b0;
  logic cs_n = 1'b0, cs2_n = 1'b0, cs2p = 1'b1, oe_n = 1'b0, poff = 1'b0;
  logic [3:0] lw = 4'hF, op;
  logic [14:0] addr = 15'h0000;
  logic [35:0] wr = 36'h0, pin;
  logic [31:0] od;
  logic doe, poe;
  int err_total = 0, checks_done = 0, cyc = 0;
  localparam logic [35:0] MIX = 36'hA_FF00_FF00;
  // free running clock
  always #5 i_clk = ~i_clk;
  sbsp_port i_sbsp_port (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_word_addr_in(addr), .i_addr_strobe_cpu_n(cpu_n),
    .i_addr_strobe_ctl_n(ctl_n), .i_burst_step_n(step_n),
    .i_chip_sel_n(cs_n), .i_chip_sel_secondary_n(cs2_n),
    .i_chip_sel_positive(cs2p), .i_lane0_write_n(lw[0]),
    .i_lane1_write_n(lw[1]), .i_lane2_write_n(lw[2]),
    .i_lane3_write_n(lw[3]), .i_out_en_n(oe_n), .i_parity_off(poff),
    .i_data_lines(pin[31:0]), .i_parity_lines(pin[35:32]),
    .o_data_lines(od), .o_parity_lines(op), .o_data_oe(doe),
    .o_parity_oe(poe));
  sbsp_bus_model i_sbsp_bus_model (.i_clk(i_clk), .i_drv(drv),
    .i_wr(wr), .i_doe(doe), .i_poe(poe), .i_rd({op, od}), .o_pin(pin));
  // compare and count
  task automatic chk(input string n, input logic [35:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one bus cycle, launched just after a rising edge
  task automatic bus(input logic c, s, t, input logic [3:0] m,
                     input logic [14:0] a, input logic [35:0] d);
    @(posedge i_clk);
    cpu_n <= c;
    ctl_n <= s;
    step_n <= t;
    lw <= m;
    addr <= a;
    wr <= d;
    drv <= (m != 4'hF);
  endtask
  task automatic idle;
    bus(1'b1, 1'b1, 1'b1, 4'hF, 15'h0000, 36'h0);
  endtask
  function automatic logic [35:0] pat(input logic [14:0] a);
    return {a[3:0] ^ 4'h9, 17'h0AB00, a};
  endfunction
  task automatic wr_word(input logic [14:0] a, input logic [3:0] m,
                         input logic [35:0] d);
    bus(1'b1, 1'b0, 1'b1, m, a, d);
    idle;
  endtask
  // read lands one cycle after the address edge
  task automatic rd(input logic [14:0] a, input logic [35:0] e);
    bus(1'b1, 1'b0, 1'b1, 4'hF, a, 36'h0);
    idle;
    @(posedge i_clk);
    @(negedge i_clk);
    chk("rdata", e, {op, od});
    chk("rd_oe", 36'h1, 36'(doe));
    chk("rd_poe", 36'h1, 36'(poe));
  endtask
  // fill four words, then an interleaved burst that wraps
  task automatic t_burst;
    for (int i = 0; i < 4; i++) wr_word(15'h7FFC + 15'(i), 4'h0,
      pat(15'h7FFC + 15'(i)));
    bus(1'b1, 1'b0, 1'b1, 4'hF, 15'h7FFE, 36'h0);
    bus(1'b1, 1'b1, 1'b0, 4'hF, 15'h0000, 36'h0);
    cs2p <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      @(posedge i_clk);
      @(negedge i_clk);
      chk("burst", pat(15'h7FFE ^ 15'(k % 4)), {op, od});
    end
    idle;
    cs2p <= 1'b1;
  endtask
  // partial lane write, pins released meanwhile
  task automatic t_lanes;
    wr_word(15'h0005, 4'h0, 36'hF_FFFF_FFFF);
    bus(1'b1, 1'b0, 1'b1, 4'hA, 15'h0005, 36'h0);
    @(posedge i_clk);
    @(negedge i_clk);
    chk("wr_oe", 36'h0, 36'(doe));
    idle;
    rd(15'h0005, MIX);
  endtask
  // cpu strobe with lanes low still reads and stores nothing
  task automatic t_cpu;
    bus(1'b0, 1'b1, 1'b1, 4'h0, 15'h0005, 36'h0);
    idle;
    @(posedge i_clk);
    @(negedge i_clk);
    chk("cpu_rd", MIX, {op, od});
    rd(15'h0005, MIX);
    // write after a cpu strobe keeps advance high at the next edge,
    // then one continued write a burst step further on lane 0
    bus(1'b0, 1'b1, 1'b1, 4'hF, 15'h7FFC, 36'h0);
    bus(1'b1, 1'b1, 1'b1, 4'hE, 15'h0000, 36'h1_0000_0012);
    bus(1'b1, 1'b1, 1'b0, 4'hE, 15'h0000, 36'h0_0000_0034);
    idle;
    rd(15'h7FFC, (pat(15'h7FFC) & ~36'h1_0000_00FF)
      | 36'h1_0000_0012);
    rd(15'h7FFD, (pat(15'h7FFD) & ~36'h1_0000_00FF)
      | 36'h0_0000_0034);
  endtask
  // deselect cases; a cpu strobe with cs_n high is ignored
  task automatic t_desel;
    for (int i = 0; i < 4; i++) begin
      rd(15'h0005, MIX);
      bus(1'(i != 3), 1'(i == 3), 1'b1, 4'hF, 15'h7FFC, 36'h0);
      cs_n <= (i == 0);
      cs2_n <= (i == 1 || i == 3);
      cs2p <= (i != 2);
      idle;
      cs_n <= 1'b0;
      cs2_n <= 1'b0;
      cs2p <= 1'b1;
      @(posedge i_clk);
      @(negedge i_clk);
      chk("desel_oe", 36'h0, 36'(doe));
    end
    rd(15'h0005, MIX);
    bus(1'b0, 1'b1, 1'b1, 4'hF, 15'h7FFC, 36'h0);
    cs_n <= 1'b1;
    idle;
    cs_n <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
    chk("cpu_ignored", MIX, {op, od});
  endtask
  // output enable and parity disable act without the clock
  task automatic t_oe;
    rd(15'h0005, MIX);
    @(negedge i_clk);
    oe_n <= 1'b1;
    #1 chk("oe_off", 36'h0, 36'(doe));
    oe_n <= 1'b0;
    poff <= 1'b1;
    #1 chk("par_off", 36'h1, {35'h0, poe} ^ 36'h1);
    chk("data_on", 36'h1, 36'(doe));
    @(posedge i_clk);
    @(negedge i_clk);
    chk("par_zero", 36'h0, 36'(op));
    poff <= 1'b0;
  endtask
  // cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test;
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_burst;
    t_lanes;
    t_cpu;
    t_desel;
    t_oe;
    stop_test;
  end
endmodule
`default_nettype wire
